// ===== core/lock_counter.v
/*
 Lock detector run counter. Counts consecutive in-window edges and declares
 lock at the coded run length. Assumes edge and window inputs are pulses
 already on ref_clk.
*/
`timescale 1ns/1ps
`include "pll_cfg_map.vh"
module lock_counter
(
   // Clock and reset
   input  wire                ref_clk,
   input  wire                rst,
   // Control
   input  wire                enable,
   input  wire                train,
   input  wire [2:0]          winCode,
   // Detector events
   input  wire                edgeSeen,
   input  wire                inWindow,
   // Result
   output reg                 locked_r
);
   reg  [`CNT_W-1:0] run_r;
   reg  [`CNT_W-1:0] run_nxt;
   wire [`CNT_W-1:0] target;

   function [`CNT_W-1:0] runLength;
      input [2:0] code;
      begin
         case (code)
            3'h0:    runLength = 17'h00005;
            3'h1:    runLength = 17'h00020;
            3'h2:    runLength = 17'h00060;
            3'h3:    runLength = 17'h00100;
            3'h4:    runLength = 17'h00200;
            3'h5:    runLength = 17'h00800;
            3'h6:    runLength = 17'h02000;
            default: runLength = 17'h0ffff;
         endcase
      end
   endfunction

   assign target = runLength(winCode);

   always @*
   begin
      run_nxt = run_r;
      if (!enable || train)
         run_nxt = {`CNT_W{1'b0}};
      else if (edgeSeen && !inWindow)
         run_nxt = {`CNT_W{1'b0}};
      else if (edgeSeen && run_r < target)
         run_nxt = run_r + 17'h00001;
   end

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         run_r    <= {`CNT_W{1'b0}};
         locked_r <= 1'b0;
      end
      else
      begin
         run_r    <= run_nxt;
         locked_r <= enable && !train && (run_nxt >= target);
      end
   end
endmodule

// ===== core/pll_lock_detect_pump_config.v
/*
 Configuration bank for lock detect, analog enables and charge pump, with
 the lock counter, slip guard and readback pin control it steers. Assumes
 the serial shifter delivers a one-cycle write strobe with address and data
 on ref_clk, and that phase error arrives as a percentage of the period.
*/
`timescale 1ns/1ps
`include "pll_cfg_map.vh"
module pll_lock_detect_pump_config
(
   // Clock and reset
   input  wire                ref_clk,
   input  wire                rst,
   // Register port from the serial shifter
   input  wire                wrStrobe,
   input  wire [`ADDR_W-1:0]  wrAddr,
   input  wire [`REG_W-1:0]   wrData,
   input  wire [`ADDR_W-1:0]  rdAddr,
   output reg  [`REG_W-1:0]   rdData_r,
   // Readback companion bit and chip address
   input  wire                readbackMode,
   input  wire [2:0]          chipAddr,
   input  wire                readbackData,
   // Phase detector events
   input  wire                divEdge,
   input  wire                inWindow,
   input  wire [6:0]          phaseErrPct,
   // Lock readback pin
   output reg                 lockReadbackPinOut_r,
   output reg                 lockReadbackPinOe_r,
   output reg                 pinHighLevel_r,
   // Analog controls
   output reg                 lockIndicator_r,
   output reg                 slipBoost_r,
   output reg                 biasEnable_r,
   output reg                 highFreqRef_r,
   output wire [`CUR_W-1:0]   upMicroAmp_r,
   output wire [`CUR_W-1:0]   dnMicroAmp_r
);
   reg  [`REG_W-1:0] lockCfg_r;
   reg  [`REG_W-1:0] analogCfg_r;
   reg  [`REG_W-1:0] pumpCfg_r;
   reg               trainPrev_r;
   reg               trainPulse_r;
   wire              locked;
   wire              trainBit;
   wire              slipNxt;

   assign trainBit = lockCfg_r[`LK_TRAIN_BIT];

   // Register writes and reads
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         lockCfg_r   <= `RST_LOCK;
         analogCfg_r <= `RST_ANALOG;
         pumpCfg_r   <= `RST_PUMP;
         rdData_r    <= {`REG_W{1'b0}};
      end
      else
      begin
         if (wrStrobe && wrAddr == `ADDR_LOCK)
            lockCfg_r <= wrData;
         if (wrStrobe && wrAddr == `ADDR_ANALOG)
            analogCfg_r <= wrData;
         if (wrStrobe && wrAddr == `ADDR_PUMP)
            pumpCfg_r <= wrData;
         case (rdAddr)
            `ADDR_LOCK:   rdData_r <= lockCfg_r;
            `ADDR_ANALOG: rdData_r <= analogCfg_r;
            `ADDR_PUMP:   rdData_r <= pumpCfg_r;
            default:      rdData_r <= {`REG_W{1'b0}};
         endcase
      end
   end

   // Training starts on a rising edge of the stored bit only
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         trainPrev_r  <= 1'b0;
         trainPulse_r <= 1'b0;
      end
      else
      begin
         trainPrev_r  <= trainBit;
         trainPulse_r <= trainBit && !trainPrev_r;
      end
   end

   lock_counter u_lock
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .enable   (lockCfg_r[`LK_EN_BIT]),
      .train    (trainPulse_r),
      .winCode  (lockCfg_r[`LK_WIN_HI:`LK_WIN_LO]),
      .edgeSeen (divEdge),
      .inWindow (inWindow),
      .locked_r (locked)
   );

   assign slipNxt = lockCfg_r[`LK_SLIP_BIT] && divEdge
                 && (phaseErrPct > 7'd`SLIP_PCT);

   pump_current u_pump
   (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .dnGain       (pumpCfg_r[`CP_DN_HI:`CP_DN_LO]),
      .upGain       (pumpCfg_r[`CP_UP_HI:`CP_UP_LO]),
      .ofsMag       (pumpCfg_r[`CP_OFS_HI:`CP_OFS_LO]),
      .ofsUpEn      (pumpCfg_r[`CP_OFSUP_BIT]),
      .ofsDnEn      (pumpCfg_r[`CP_OFSDN_BIT]),
      .highGain     (pumpCfg_r[`CP_HIK_BIT]),
      .slipBoost    (slipNxt),
      .upMicroAmp_r (upMicroAmp_r),
      .dnMicroAmp_r (dnMicroAmp_r)
   );

   // Pin and analog control outputs
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         lockReadbackPinOut_r <= 1'b0;
         lockReadbackPinOe_r  <= 1'b0;
         pinHighLevel_r       <= 1'b0;
         lockIndicator_r      <= 1'b0;
         slipBoost_r          <= 1'b0;
         biasEnable_r         <= 1'b0;
         highFreqRef_r        <= 1'b0;
      end
      else
      begin
         lockIndicator_r <= locked;
         slipBoost_r     <= slipNxt;
         biasEnable_r    <= analogCfg_r[`AN_BIAS_BIT];
         highFreqRef_r   <= analogCfg_r[`AN_HIREF_BIT];
         pinHighLevel_r  <= analogCfg_r[`AN_LEVEL_BIT];
         if (!analogCfg_r[`AN_GPO_BIT])
         begin
            lockReadbackPinOe_r  <= 1'b0;
            lockReadbackPinOut_r <= 1'b0;
         end
         else if (readbackMode)
         begin
            lockReadbackPinOe_r  <= 1'b1;
            lockReadbackPinOut_r <= readbackData;
         end
         else
         begin
            lockReadbackPinOe_r  <= (chipAddr == `CHIP_ADDR_SH);
            lockReadbackPinOut_r <= readbackData;
         end
      end
   end
endmodule

// ===== core/pump_current.v
/*
 Charge pump current computation in microamps from gain, offset and boost
 settings. Assumes the analog pump takes these codes as sink/source totals.
*/
`timescale 1ns/1ps
`include "pll_cfg_map.vh"
module pump_current
(
   // Clock and reset
   input  wire                ref_clk,
   input  wire                rst,
   // Settings
   input  wire [6:0]          dnGain,
   input  wire [6:0]          upGain,
   input  wire [6:0]          ofsMag,
   input  wire                ofsUpEn,
   input  wire                ofsDnEn,
   input  wire                highGain,
   input  wire                slipBoost,
   // Currents in microamps
   output reg  [`CUR_W-1:0]   upMicroAmp_r,
   output reg  [`CUR_W-1:0]   dnMicroAmp_r
);
   function [`CUR_W-1:0] scale;
      input [6:0] code;
      input [4:0] step;
      begin
         scale = code * step;
      end
   endfunction

   wire [`CUR_W-1:0] extra;
   wire [`CUR_W-1:0] ofs;
   wire [`CUR_W-1:0] upNxt;
   wire [`CUR_W-1:0] dnNxt;

   assign extra = (highGain  ? 14'd`HIK_UA  : 14'd0)
                + (slipBoost ? 14'd`SLIP_UA : 14'd0);
   assign ofs   = scale(ofsMag, 5'd`STEP_OFS_UA);
   assign upNxt = scale(upGain, 5'd`STEP_DN_UA) + extra
                + (ofsUpEn ? ofs : 14'd0);
   assign dnNxt = scale(dnGain, 5'd`STEP_DN_UA) + extra
                + (ofsDnEn ? ofs : 14'd0);

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         upMicroAmp_r <= {`CUR_W{1'b0}};
         dnMicroAmp_r <= {`CUR_W{1'b0}};
      end
      else
      begin
         upMicroAmp_r <= upNxt;
         dnMicroAmp_r <= dnNxt;
      end
   end
endmodule

// ===== include/pll_cfg_map.vh
/*
 Register map and timing constants of the lock detect, analog enable and
 charge pump configuration bank. Assumes a host that writes whole 24-bit
 registers over the serial register port.
*/
`ifndef PLL_CFG_MAP_VH
`define PLL_CFG_MAP_VH

`define REG_W          24
`define ADDR_W         5
`define ADDR_LOCK      5'h07
`define ADDR_ANALOG    5'h08
`define ADDR_PUMP      5'h09
`define RST_LOCK       24'h200844
`define RST_ANALOG     24'h01bfff
`define RST_PUMP       24'h547264

`define LK_WIN_HI      2
`define LK_WIN_LO      0
`define LK_EN_BIT      11
`define LK_TRAIN_BIT   20
`define LK_SLIP_BIT    21
`define AN_GPO_BIT     5
`define AN_BIAS_BIT    10
`define AN_HIREF_BIT   21
`define AN_LEVEL_BIT   22
`define CP_DN_HI       6
`define CP_DN_LO       0
`define CP_UP_HI       13
`define CP_UP_LO       7
`define CP_OFS_HI      20
`define CP_OFS_LO      14
`define CP_OFSUP_BIT   21
`define CP_OFSDN_BIT   22
`define CP_HIK_BIT     23

`define CNT_W          17
`define STEP_DN_UA     20
`define STEP_OFS_UA    5
`define SLIP_UA        6000
`define HIK_UA         3000
`define CUR_W          14
`define SLIP_PCT       70
`define CHIP_ADDR_SH   3'h0

`endif

// ===== tb/host_model.sv
/* Host model that writes and reads the bank's register port.
   Assumes a one-cycle write strobe sampled on rising ref_clk. */
`timescale 1ns/1ps
`include "pll_cfg_map.vh"
module host_model
(
   // Clock
   input  wire logic              ref_clk,
   // Register port
   output logic                   wrStrobe,
   output logic [`ADDR_W-1:0]     wrAddr,
   output logic [`REG_W-1:0]      wrData,
   output logic [`ADDR_W-1:0]     rdAddr,
   input  wire logic [`REG_W-1:0] rdData_r
);
   initial
   begin
      wrStrobe = 1'b0;
      wrAddr = 5'h00;
      wrData = 24'h000000;
      rdAddr = 5'h00;
   end
   task write(input logic [4:0] a, input logic [23:0] d);
      @(negedge ref_clk);
      wrStrobe = 1'b1;
      wrAddr = a;
      wrData = d;
      @(negedge ref_clk);
      wrStrobe = 1'b0;
      wrData = ~d;
   endtask
   task read(input logic [4:0] a, output logic [23:0] d);
      @(negedge ref_clk);
      rdAddr = a;
      @(negedge ref_clk);
      d = rdData_r;
   endtask
   // Training bit low then high
   task retrain(input logic [23:0] d);
      write(`ADDR_LOCK, d & 24'hefffff);
      write(`ADDR_LOCK, d | 24'h100000);
   endtask
endmodule

// ===== tb/pll_cfg_checker.sv
/* Port checker for the configuration bank.
   Bound to the top module; sees only its ports. */
`timescale 1ns/1ps
`include "pll_cfg_map.vh"
module pll_cfg_checker
(
   // Clock, reset and writes
   input wire logic               ref_clk,
   input wire logic               rst,
   input wire logic               wrStrobe,
   input wire logic [`ADDR_W-1:0] wrAddr,
   input wire logic [`REG_W-1:0]  wrData,
   // Pin and detector inputs
   input wire logic               readbackMode,
   input wire logic [2:0]         chipAddr,
   input wire logic               divEdge,
   input wire logic               inWindow,
   input wire logic [6:0]         phaseErrPct,
   // Outputs watched
   input wire logic               lockReadbackPinOe_r,
   input wire logic               pinHighLevel_r,
   input wire logic               lockIndicator_r,
   input wire logic               slipBoost_r,
   input wire logic               biasEnable_r,
   input wire logic               highFreqRef_r
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire wrA = wrStrobe && wrAddr == `ADDR_ANALOG;
   wire wrL = wrStrobe && wrAddr == `ADDR_LOCK;
   a_bias_follows: assert property (
      wrA |-> ##2 biasEnable_r == $past(wrData[10], 2))
      else $error("bias enable wrong");
   a_level_follows: assert property (
      wrA |-> ##2 pinHighLevel_r == $past(wrData[22], 2))
      else $error("pin level wrong");
   a_hiref_follows: assert property (
      wrA |-> ##2 highFreqRef_r == $past(wrData[21], 2))
      else $error("high ref wrong");
   a_pin_off: assert property (
      wrA && !wrData[5] |-> ##2 !lockReadbackPinOe_r)
      else $error("pin driven while disabled");
   a_pin_gpo: assert property (
      wrA && wrData[5] ##1 readbackMode |=> lockReadbackPinOe_r)
      else $error("pin not driven");
   a_pin_shared: assert property (
      wrA && wrData[5] ##1 (!readbackMode && chipAddr != 3'h0)
      |=> !lockReadbackPinOe_r) else $error("shared pin driven");
   a_slip_cause: assert property (
      slipBoost_r |-> $past(divEdge) && $past(phaseErrPct) > 7'd70)
      else $error("slip boost without cause");
   a_lock_edge: assert property (
      $rose(lockIndicator_r) |-> $past(divEdge && inWindow, 2)
      || $past(divEdge && inWindow, 3)) else $error("lock without edge");
   a_ld_gate: assert property (
      wrL && !wrData[11] ##1 !wrStrobe [*4] |-> !lockIndicator_r)
      else $error("lock while detector off");
endmodule

// ===== tb/test_pll_lock_detect_pump_config.sv
/* Self-checking bench for the configuration bank.
   Assumes the host model drives the register port. */
`timescale 1ns/1ps
`include "pll_cfg_map.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   n_errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module test_pll_lock_detect_pump_config;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        readbackMode = 1'b0;
   logic        readbackData = 1'b0;
   logic        divEdge = 1'b0;
   logic        inWindow = 1'b0;
   logic [2:0]  chipAddr = 3'h0;
   logic [6:0]  phaseErrPct = 7'h00;
   logic        wrStrobe, lockReadbackPinOut_r, lockReadbackPinOe_r;
   logic        pinHighLevel_r, lockIndicator_r, slipBoost_r;
   logic        biasEnable_r, highFreqRef_r;
   logic [4:0]  wrAddr, rdAddr;
   logic [23:0] wrData, rdData_r, d;
   logic [13:0] upMicroAmp_r, dnMicroAmp_r;
   int          n_errors = 0;
   int          checks_done = 0;
   logic [23:0] rv[4] = '{`RST_LOCK, `RST_ANALOG, `RST_PUMP, 24'h0};
   logic [23:0] pw[2] = '{24'h3fc07f, 24'hc07f80};
   logic [27:0] pc[2] = '{{14'd635, 14'd2540}, {14'd5540, 14'd3005}};
   logic [4:0]  pin[3] = '{5'b1_101_1, 5'b0_101_0, 5'b0_000_1};
   int          rl[3] = '{5, 32, 96};
   always #2.5 ref_clk = ~ref_clk;
   host_model host (.ref_clk, .wrStrobe, .wrAddr, .wrData, .rdAddr,
      .rdData_r);
   pll_lock_detect_pump_config DUT (.ref_clk, .rst, .wrStrobe, .wrAddr,
      .wrData, .rdAddr, .rdData_r, .readbackMode, .chipAddr, .readbackData,
      .divEdge, .inWindow, .phaseErrPct, .lockReadbackPinOut_r,
      .lockReadbackPinOe_r, .pinHighLevel_r, .lockIndicator_r,
      .slipBoost_r, .biasEnable_r, .highFreqRef_r, .upMicroAmp_r,
      .dnMicroAmp_r);
   task final_report;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task settle;
      repeat (3) @(negedge ref_clk);
   endtask
   task pulse(input logic w, input logic [6:0] p, input logic s);
      @(negedge ref_clk);
      divEdge = 1'b1;
      inWindow = w;
      phaseErrPct = p;
      @(negedge ref_clk);
      `CHK("slip", s, slipBoost_r)
      divEdge = 1'b0;
   endtask
   task lockrun(input int n, input logic e);
      repeat (n) pulse(1'b1, 7'd0, 1'b0);
      settle;
      `CHK("lock", e, lockIndicator_r)
   endtask
   initial
   begin
      #100000;
      n_errors++;
      final_report;
   end
   initial
   begin
      repeat (4) @(negedge ref_clk);
      rst = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         host.read(5'h07 + i[4:0], d);
         `CHK("reg", rv[i], d)
      end
      `CHK("cur", {14'd2000, 14'd2405}, {upMicroAmp_r, dnMicroAmp_r})
      for (int i = 0; i < 2; i++)
      begin
         host.write(`ADDR_PUMP, pw[i]);
         host.read(`ADDR_PUMP, d);
         settle;
         `CHK("cur", pc[i], {upMicroAmp_r, dnMicroAmp_r})
      end
      host.write(`ADDR_ANALOG, 24'h61bbdf);
      settle;
      `CHK("ana", 4'b0011, {lockReadbackPinOe_r, biasEnable_r,
         highFreqRef_r, pinHighLevel_r})
      readbackData = 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         {readbackMode, chipAddr} = pin[i][4:1];
         host.write(`ADDR_ANALOG, `RST_ANALOG);
         settle;
         `CHK("oe", pin[i][0], lockReadbackPinOe_r)
         `CHK("pin", 1'b1, lockReadbackPinOut_r)
      end
      for (int c = 0; c < 3; c++)
      begin
         host.retrain(24'h200840 | c);
         lockrun(rl[c] - 1, 1'b0);
         pulse(1'b0, 7'd0, 1'b0);
         lockrun(rl[c] - 1, 1'b0);
         lockrun(1, 1'b1);
         host.write(`ADDR_LOCK, 24'h300840 | c);
         settle;
         `CHK("keep", 1'b1, lockIndicator_r)
         host.write(`ADDR_LOCK, 24'h300040);
         settle;
         `CHK("off", 1'b0, lockIndicator_r)
      end
      host.write(`ADDR_LOCK, `RST_LOCK);
      // Boost adds 6000 uA on both currents for the slipping cycle
      @(negedge ref_clk);
      divEdge = 1'b1;
      inWindow = 1'b1;
      phaseErrPct = 7'd80;
      @(negedge ref_clk);
      `CHK("boost", {14'd11540, 14'd9005}, {upMicroAmp_r, dnMicroAmp_r})
      divEdge = 1'b0;
      pulse(1'b1, 7'd71, 1'b1);
      pulse(1'b1, 7'd70, 1'b0);
      host.write(`ADDR_LOCK, 24'h000844);
      pulse(1'b1, 7'd90, 1'b0);
      final_report;
   end
endmodule
bind pll_lock_detect_pump_config pll_cfg_checker chk (.ref_clk, .rst,
   .wrStrobe, .wrAddr, .wrData, .readbackMode, .chipAddr, .divEdge,
   .inWindow, .phaseErrPct, .lockReadbackPinOe_r, .pinHighLevel_r,
   .lockIndicator_r, .slipBoost_r, .biasEnable_r, .highFreqRef_r);
